// [rtl/mpf_top.sv]
// Summary of operation
// - Three generators drive complementary high/low pairs
// - Sixteen-bit period and duty, changeable while running
// - Edge, center and single-pulse modes
// - Duty updates immediate or at timebase boundary
// - Special-event compare on timebase gives trigger
// - Center mode flags both half and full period
// - Software override sets each output directly
// - Either fault forces per-pin safe state
// - Enabled fault input enables weak pull-down
// - Fault pins stay owned through reset
// - Faults come out of reset enabled, latched
// - Latched fault clears on pin high plus flag clear
// - Outputs resume at next period or half boundary
// - Three control registers are write-protected
// - Lock fuse one protects, zero disables protection
// - Key pair unlocks one protected write
// - Any other access voids the unlock
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mpf_defs.svh"

module mpf_top
    import mpf_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic fault_input_a,
    input wire logic fault_input_b,
    input wire logic write_lock_fuse,
    output logic [2:0] high_side_output,
    output logic [2:0] low_side_output,
    output logic fault_a_pulldown_en,
    output logic fault_b_pulldown_en,
    output logic special_trigger,
    output logic update_event
);

    // ======================================================
    // Bus phase tracking
    logic wr_ph_r, rd_ph_r, word_ph_r, hready_r;
    logic [7:0] addr_ph_r;
    logic [31:0] hrdata_r;
    wire acc = hsel && htrans[1] && hready;
    // Reads take one wait state so they see a write just before
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_r <= 1'b0;
            rd_ph_r <= 1'b0;
            word_ph_r <= 1'b0;
            addr_ph_r <= 8'h00;
            hready_r <= 1'b1;
        end else begin
            wr_ph_r <= acc && hwrite;
            rd_ph_r <= acc && !hwrite;
            word_ph_r <= hsize == `MPF_HSIZE_WORD;
            if (acc) begin
                addr_ph_r <= haddr[7:0];
            end
            hready_r <= !(acc && !hwrite);
        end
    end

    wire sfr_acc = wr_ph_r || rd_ph_r;
    wire wr = wr_ph_r && word_ph_r;
    wire mpf_word_t wdat = hwdata[15:0];
    wire sel_con1 = addr_ph_r == `MPF_OFF_CON1;
    wire sel_per = addr_ph_r == `MPF_OFF_PER;
    wire sel_d1 = addr_ph_r == `MPF_OFF_DUTY1;
    wire sel_d2 = addr_ph_r == `MPF_OFF_DUTY2;
    wire sel_d3 = addr_ph_r == `MPF_OFF_DUTY3;
    wire sel_ovr = addr_ph_r == `MPF_OFF_OVR;
    wire sel_sevt = addr_ph_r == `MPF_OFF_SEVT;
    wire sel_flta = addr_ph_r == `MPF_OFF_FLTA;
    wire sel_fltb = addr_ph_r == `MPF_OFF_FLTB;
    wire sel_key = addr_ph_r == `MPF_OFF_KEY;
    wire sel_stat = addr_ph_r == `MPF_OFF_STAT;
    // ======================================================
    // Pin synchronisers
    logic fuse_m_r, fuse_s_r, pina_m_r, pina_s_r, pinb_m_r, pinb_s_r;
    // Reset values: protection on, both faults seen asserted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_m_r <= 1'b1;
            fuse_s_r <= 1'b1;
            pina_m_r <= 1'b0;
            pina_s_r <= 1'b0;
            pinb_m_r <= 1'b0;
            pinb_s_r <= 1'b0;
        end else begin
            fuse_m_r <= write_lock_fuse;
            fuse_s_r <= fuse_m_r;
            pina_m_r <= fault_input_a;
            pina_s_r <= pina_m_r;
            pinb_m_r <= fault_input_b;
            pinb_s_r <= pinb_m_r;
        end
    end

    // ======================================================
    // Unlock sequence
    mpf_lock_state_t lk_r, lk_nxt;
    wire key_wr = wr && sel_key;
    always_comb begin
        case (lk_r)
            MPF_LK_IDLE: begin
                lk_nxt = (key_wr && wdat == `MPF_KEY1) ? MPF_LK_KEY1
                                                         : MPF_LK_IDLE;
            end
            MPF_LK_KEY1: begin
                if (sfr_acc) begin
                    lk_nxt = (key_wr && wdat == `MPF_KEY2) ? MPF_LK_OPEN
                                                             : MPF_LK_IDLE;
                end else begin
                    lk_nxt = MPF_LK_KEY1;
                end
            end
            MPF_LK_OPEN: begin
                lk_nxt = sfr_acc ? MPF_LK_IDLE : MPF_LK_OPEN;
            end
            default: begin
                lk_nxt = MPF_LK_IDLE;
            end
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lk_r <= MPF_LK_IDLE;
        end else begin
            lk_r <= lk_nxt;
        end
    end
    wire wr_allow = !fuse_s_r || lk_r == MPF_LK_OPEN;
    wire wr_con1 = wr && sel_con1 && wr_allow;
    wire wr_flta = wr && sel_flta && wr_allow;
    wire wr_fltb = wr && sel_fltb && wr_allow;

    // ======================================================
    // Software registers
    mpf_word_t con1_r, per_r, ovr_r, sevt_r, flta_r, fltb_r;
    mpf_word_t duty_r [3];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            con1_r <= `MPF_RST_CON1;
            per_r <= `MPF_RST_PER;
            ovr_r <= `MPF_RST_ZERO;
            sevt_r <= `MPF_RST_ZERO;
            flta_r <= `MPF_RST_FLT;
            fltb_r <= `MPF_RST_FLT;
            duty_r[0] <= `MPF_RST_ZERO;
            duty_r[1] <= `MPF_RST_ZERO;
            duty_r[2] <= `MPF_RST_ZERO;
        end else begin
            if (wr_con1) con1_r <= wdat;
            if (wr && sel_per) per_r <= wdat;
            if (wr && sel_ovr) ovr_r <= wdat;
            if (wr && sel_sevt) sevt_r <= wdat;
            if (wr_flta) flta_r <= wdat;
            if (wr_fltb) fltb_r <= wdat;
            if (wr && sel_d1) duty_r[0] <= wdat;
            if (wr && sel_d2) duty_r[1] <= wdat;
            if (wr && sel_d3) duty_r[2] <= wdat;
        end
    end

    // ======================================================
    // Timebase
    mpf_tb_if tb ();
    logic [15:0] cnt_r, per_act_r;
    logic down_r, sp_done_r;
    wire en = con1_r[`MPF_CON1_EN];
    wire ctr = con1_r[`MPF_CON1_CTR];
    wire run = en && !sp_done_r;
    wire at_top = cnt_r >= per_act_r;
    wire full_ev = run && (ctr ? (down_r && cnt_r == 16'h0000)
                               : at_top);
    wire half_ev = run && ctr && !down_r && at_top;
    wire bnd = full_ev || half_ev || !run;
    assign tb.count = cnt_r;
    assign tb.run = run;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 16'h0000;
            down_r <= 1'b0;
            sp_done_r <= 1'b0;
            per_act_r <= `MPF_RST_PER;
        end else begin
            if (full_ev || !run) per_act_r <= per_r;
            if (wr_con1) begin
                sp_done_r <= 1'b0;
            end else if (full_ev && con1_r[`MPF_CON1_SP]) begin
                sp_done_r <= 1'b1;
            end
            if (!run) begin
                cnt_r <= 16'h0000;
                down_r <= 1'b0;
            end else if (half_ev) begin
                cnt_r <= cnt_r - 16'h0001;
                down_r <= 1'b1;
            end else if (full_ev) begin
                cnt_r <= ctr ? 16'h0001 : 16'h0000;
                down_r <= 1'b0;
            end else if (down_r) begin
                cnt_r <= cnt_r - 16'h0001;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // ======================================================
    // Duty generators
    mpf_word_t duty_act_r [3];
    logic [2:0] gen_h;
    wire imm = con1_r[`MPF_CON1_IMM];
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    duty_act_r[gi] <= `MPF_RST_ZERO;
                end else if (imm || bnd) begin
                    duty_act_r[gi] <= duty_r[gi];
                end
            end
            mpf_chan u_chan (
                .tb(tb.snk),
                .duty(duty_act_r[gi]),
                .high(gen_h[gi])
            );
        end
    endgenerate

    // ======================================================
    // Faults
    logic hold_a_r, hold_b_r;
    logic [4:0] flag_r;
    logic [4:0] flag_set;
    logic [4:0] flag_clr;
    wire fa_en = flta_r[`MPF_FLT_EN];
    wire fb_en = fltb_r[`MPF_FLT_EN];
    wire fa_act = fa_en && (flta_r[`MPF_FLT_LAT] ? flag_r[`MPF_ST_FLTA]
                                                 : !pina_s_r);
    wire fb_act = fb_en && (fltb_r[`MPF_FLT_LAT] ? flag_r[`MPF_ST_FLTB]
                                                 : !pinb_s_r);
    wire force_a = fa_act || hold_a_r;
    wire force_b = fb_act || hold_b_r;
    wire sevt_hit = run && cnt_r == sevt_r;
    assign flag_set = {half_ev, full_ev, sevt_hit,
                       fb_en && !pinb_s_r, fa_en && !pina_s_r};
    assign flag_clr = (wr && sel_stat) ? hwdata[4:0] : 5'h00;
    // Set beats clear, so a fault pin still low keeps its flag
    generate
        for (gi = 0; gi < 5; gi++) begin : g_flag
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    flag_r[gi] <= (gi < 2);
                end else begin
                    flag_r[gi] <= flag_set[gi] ||
                                  (flag_r[gi] && !flag_clr[gi]);
                end
            end
        end
    endgenerate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_a_r <= 1'b1;
            hold_b_r <= 1'b1;
        end else begin
            hold_a_r <= fa_act || (hold_a_r && !bnd);
            hold_b_r <= fb_act || (hold_b_r && !bnd);
        end
    end
    // ======================================================
    // Output stage
    logic [5:0] pin_nxt;
    wire [5:0] ovr_en = ovr_r[5:0];
    wire [5:0] ovr_val = ovr_r[`MPF_OVR_VAL_LSB +: 6];
    wire [5:0] safe_a = flta_r[`MPF_FLT_SAFE_LSB +: 6];
    wire [5:0] safe_b = fltb_r[`MPF_FLT_SAFE_LSB +: 6];
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            wire gh = ovr_en[2*gi] ? ovr_val[2*gi] : gen_h[gi];
            wire gl = ovr_en[2*gi+1] ? ovr_val[2*gi+1]
                                     : (run && !gen_h[gi]);
            assign pin_nxt[2*gi] = force_a ? safe_a[2*gi] :
                                   force_b ? safe_b[2*gi] : gh;
            assign pin_nxt[2*gi+1] = force_a ? safe_a[2*gi+1] :
                                     force_b ? safe_b[2*gi+1] : gl;
        end
    endgenerate

    // ======================================================
    // Read mux
    wire [15:0] stat_rd = {6'h00, pinb_s_r, pina_s_r, 1'b0, fuse_s_r,
                           lk_r == MPF_LK_OPEN, flag_r};
    wire [15:0] rd_mux =
        sel_con1 ? con1_r : sel_per ? per_r :
        sel_d1 ? duty_r[0] : sel_d2 ? duty_r[1] :
        sel_d3 ? duty_r[2] : sel_ovr ? ovr_r :
        sel_sevt ? sevt_r : sel_flta ? flta_r :
        sel_fltb ? fltb_r : sel_stat ? stat_rd : 16'h0000;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
            high_side_output <= 3'h0;
            low_side_output <= 3'h0;
            fault_a_pulldown_en <= 1'b1;
            fault_b_pulldown_en <= 1'b1;
            special_trigger <= 1'b0;
            update_event <= 1'b0;
        end else begin
            if (rd_ph_r) hrdata_r <= {16'h0000, rd_mux};
            high_side_output <= {pin_nxt[4], pin_nxt[2], pin_nxt[0]};
            low_side_output <= {pin_nxt[5], pin_nxt[3], pin_nxt[1]};
            fault_a_pulldown_en <= fa_en;
            fault_b_pulldown_en <= fb_en;
            special_trigger <= sevt_hit;
            update_event <= full_ev || half_ev;
        end
    end
    assign hrdata = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp = 1'b0;
endmodule : mpf_top

`default_nettype wire

// [include/mpf_defs.svh]
`ifndef MPF_DEFS_SVH
`define MPF_DEFS_SVH

// ==========================================================
// Register byte offsets
`define MPF_OFF_CON1 8'h00
`define MPF_OFF_PER 8'h04
`define MPF_OFF_DUTY1 8'h08
`define MPF_OFF_DUTY2 8'h0C
`define MPF_OFF_DUTY3 8'h10
`define MPF_OFF_OVR 8'h14
`define MPF_OFF_SEVT 8'h18
`define MPF_OFF_FLTA 8'h1C
`define MPF_OFF_FLTB 8'h20
`define MPF_OFF_KEY 8'h24
`define MPF_OFF_STAT 8'h28

// ==========================================================
// Field positions
`define MPF_CON1_EN 0
`define MPF_CON1_CTR 1
`define MPF_CON1_SP 2
`define MPF_CON1_IMM 3
`define MPF_FLT_EN 0
`define MPF_FLT_LAT 1
`define MPF_FLT_SAFE_LSB 8
`define MPF_OVR_VAL_LSB 8
`define MPF_ST_FLTA 0
`define MPF_ST_FLTB 1
`define MPF_ST_SEVT 2
`define MPF_ST_FULL 3
`define MPF_ST_HALF 4
`define MPF_ST_UNLK 5
`define MPF_ST_FUSE 6
`define MPF_ST_PINA 8
`define MPF_ST_PINB 9

// ==========================================================
// Reset values and keys
`define MPF_RST_CON1 16'h0000
`define MPF_RST_PER 16'hFFFF
`define MPF_RST_ZERO 16'h0000
`define MPF_RST_FLT 16'h0003
`define MPF_KEY1 16'hABCD
`define MPF_KEY2 16'h4321
`define MPF_HSIZE_WORD 3'h2

`endif

// [include/mpf_pkg.sv]
package mpf_pkg;

    typedef logic [15:0] mpf_word_t;

    typedef enum logic [2:0] {
        MPF_LK_IDLE = 3'h1,
        MPF_LK_KEY1 = 3'h2,
        MPF_LK_OPEN = 3'h4
    } mpf_lock_state_t;

endpackage : mpf_pkg

// [include/mpf_tb_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface mpf_tb_if;
    logic [15:0] count;
    logic run;
    modport src (output count, output run);
    modport snk (input count, input run);
endinterface : mpf_tb_if

`default_nettype wire

// [rtl/mpf_chan.sv]
`timescale 1ns/1ps
`default_nettype none

module mpf_chan
    import mpf_pkg::*;
(
    mpf_tb_if.snk tb,
    input wire mpf_word_t duty,
    output logic high
);

    // Same compare serves both alignments: up/down count centres the pulse
    assign high = tb.run && (tb.count < duty);

endmodule : mpf_chan

`default_nettype wire

// [test/mpf_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks
module mpf_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [2:0] high_side_output,
    input wire logic [2:0] low_side_output,
    input wire logic fault_a_pulldown_en,
    input wire logic fault_b_pulldown_en,
    input wire logic special_trigger,
    input wire logic update_event
);
    wire logic tk = hsel & htrans[1] & hready;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_ok;
        hresp == 1'b0;
    endproperty
    a_ok: assert property (p_ok) else $error("hresp not okay");
    property p_rd;
        tk && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd: assert property (p_rd) else $error("read wait wrong");
    property p_wr;
        tk && hwrite |=> hreadyout;
    endproperty
    a_wr: assert property (p_wr) else $error("write stalled");
    property p_one;
        !hreadyout |=> hreadyout;
    endproperty
    a_one: assert property (p_one) else $error("wait too long");
    property p_trg;
        special_trigger |=> !special_trigger;
    endproperty
    a_trg: assert property (p_trg) else $error("trigger wide");
    property p_upd;
        update_event |=> !update_event;
    endproperty
    a_upd: assert property (p_upd) else $error("update wide");
    // Reset must leave both fault pins guarded
    property p_pd;
        $rose(hresetn) |-> fault_a_pulldown_en && fault_b_pulldown_en;
    endproperty
    a_pd: assert property (p_pd) else $error("pulldown off");
    property p_safe;
        $rose(hresetn) |-> (high_side_output | low_side_output) == 3'h0;
    endproperty
    a_safe: assert property (p_safe) else $error("outputs live");
    c_rd: cover property (tk && !hwrite);
    c_trg: cover property (special_trigger);
    c_upd: cover property (update_event);
endmodule : mpf_chk

bind mpf_top mpf_chk i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .high_side_output(high_side_output),
    .low_side_output(low_side_output),
    .fault_a_pulldown_en(fault_a_pulldown_en),
    .fault_b_pulldown_en(fault_b_pulldown_en),
    .special_trigger(special_trigger), .update_event(update_event)
);
`default_nettype wire

// [test/mpf_stage.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Fault sensing side
module mpf_stage (
    input wire logic hclk,
    input wire logic flt_a,
    input wire logic flt_b,
    input wire logic brk_a,
    input wire logic pd_a,
    output logic fault_input_a,
    output logic fault_input_b
);
    logic tgl = 1'b0;
    // Open wire floats; only the pull-down gives a level
    always @(posedge hclk) tgl <= ~tgl;
    assign fault_input_a = brk_a ? (pd_a ? 1'b0 : tgl) : ~flt_a;
    assign fault_input_b = ~flt_b;
endmodule : mpf_stage
`default_nettype wire

// [test/mpf_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module mpf_top_tb;
    logic hclk, hresetn, hsel, hwrite, fuse, fa, fb, ba;
    logic [31:0] haddr, hwdata;
    logic [15:0] q, e;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire [31:0] hrdata;
    wire [2:0] hi, lo;
    wire hrdy, fia, fib, pda, pdb, trg, upd;
    int n_errors, checks, nh, nu, nt, nc;
    mpf_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(), .fault_input_a(fia),
        .fault_input_b(fib), .write_lock_fuse(fuse),
        .high_side_output(hi), .low_side_output(lo),
        .fault_a_pulldown_en(pda), .fault_b_pulldown_en(pdb),
        .special_trigger(trg), .update_event(upd)
    );
    mpf_stage i_stage (
        .hclk(hclk), .flt_a(fa), .flt_b(fb), .brk_a(ba), .pd_a(pda),
        .fault_input_a(fia), .fault_input_b(fib)
    );
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic complete_run;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [15:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // Bounded so a dead slave cannot hang the run
    task automatic rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hrdy !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            complete_run();
        end
    endtask : rdy
    task automatic xf(input logic w, input logic [7:0] a, input logic [15:0] d);
        {hsel, hwrite, htrans} <= {1'b1, w, 2'b10};
        haddr <= {24'h00_0000, a};
        rdy();
        htrans <= 2'b00;
        hwdata <= {16'h0000, d};
        rdy();
        q = hrdata[15:0];
    endtask : xf
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        xf(1'b0, a, 16'h0000);
        chk($sformatf("reg%h", a), q, x);
    endtask : rd
    task automatic cnt(input int k);
        nh = 0;
        nu = 0;
        nt = 0;
        nc = 0;
        repeat (k) begin
            @(posedge hclk);
            nh += 32'(hi[0]);
            nu += 32'(upd);
            nt += 32'(trg);
            nc += 32'(lo !== ~hi);
        end
    endtask : cnt
    initial begin
        {hresetn, hsel, htrans, hwrite, fa, fb, ba} = 8'h00;
        {fuse, hsize, haddr, hwdata} = {4'hA, 64'h0};
        repeat (8) @(posedge hclk);
        chk("pd", 16'({pda, pdb}), 16'h0003);
        hresetn <= 1'b1;
        rd(8'h1C, 16'h0003);
        rd(8'h20, 16'h0003);
        rd(8'h28, 16'h0343);
        xf(1'b1, 8'h00, 16'h0001);
        rd(8'h00, 16'h0000);
        xf(1'b1, 8'h28, 16'h0003);
        rd(8'h28, 16'h0340);
        e = 16'h0003;
        for (int i = 0; i < 4; i++) begin
            xf(1'b1, 8'h24, i == 2 ? 16'h1234 : 16'hABCD);
            if (i == 1) rd(8'h40, 16'h0000);
            xf(1'b1, 8'h24, 16'h4321);
            if (i == 3) rd(8'h40, 16'h0000);
            xf(1'b1, 8'h20, {8'(i + 1), 8'h03});
            if (i == 0) e = 16'h0103;
            rd(8'h20, e);
        end
        xf(1'b1, 8'h24, 16'hABCD);
        xf(1'b1, 8'h24, 16'h4321);
        xf(1'b1, 8'h20, 16'h0503);
        xf(1'b1, 8'h20, 16'h0F03);
        rd(8'h20, 16'h0503);
        ba <= 1'b1;
        cnt(4);
        xf(1'b0, 8'h28, 16'h0000);
        chk("brk", 16'(q[1:0]), 16'h0001);
        {ba, fuse} <= 2'b00;
        cnt(3);
        xf(1'b1, 8'h28, 16'h0003);
        rd(8'h28, 16'h0300);
        xf(1'b1, 8'h20, 16'h0003);
        xf(1'b1, 8'h1C, 16'h0000);
        cnt(2);
        chk("pd", 16'(pda), 16'h0000);
        xf(1'b1, 8'h1C, 16'h0003);
        xf(1'b1, 8'h04, 16'h0009);
        xf(1'b1, 8'h08, 16'h0004);
        xf(1'b1, 8'h10, 16'h000A);
        xf(1'b1, 8'h18, 16'h0003);
        xf(1'b1, 8'h00, 16'h0009);
        cnt(20);
        cnt(20);
        chk("duty", 16'(nh), 16'h0008);
        chk("upd", 16'(nu), 16'h0002);
        chk("trg", 16'(nt), 16'h0002);
        chk("comp", 16'(nc), 16'h0000);
        chk("hi", 16'(hi[2:1]), 16'h0002);
        xf(1'b1, 8'h14, 16'h153F);
        cnt(2);
        chk("ovr", 16'({hi, lo}), 16'h0038);
        xf(1'b1, 8'h14, 16'h0000);
        fa <= 1'b1;
        cnt(8);
        chk("safe", 16'({hi, lo}), 16'h0000);
        xf(1'b1, 8'h28, 16'h0001);
        xf(1'b0, 8'h28, 16'h0000);
        chk("flag", 16'(q[0]), 16'h0001);
        fa <= 1'b0;
        cnt(20);
        chk("held", 16'(nc), 16'h0014);
        xf(1'b1, 8'h28, 16'h0001);
        cnt(16);
        cnt(10);
        chk("back", 16'(nc), 16'h0000);
        fb <= 1'b1;
        cnt(8);
        chk("safe", 16'({hi, lo}), 16'h0000);
        fb <= 1'b0;
        cnt(4);
        xf(1'b1, 8'h28, 16'h0002);
        cnt(16);
        cnt(10);
        chk("back", 16'(nc), 16'h0000);
        xf(1'b1, 8'h00, 16'h000B);
        cnt(40);
        chk("ctr", 16'(nc), 16'h0000);
        chk("half", 16'(nu > 3), 16'h0001);
        xf(1'b1, 8'h00, 16'h0005);
        cnt(40);
        cnt(20);
        chk("one", 16'(nu), 16'h0000);
        xf(1'b1, 8'h40, 16'hFFFF);
        rd(8'h40, 16'h0000);
        // Mid-run reset must re-arm both faults and guard the pins
        hresetn <= 1'b0;
        cnt(2);
        chk("rst", 16'({pda, pdb, hi, lo}), 16'h00C0);
        hresetn <= 1'b1;
        rd(8'h1C, 16'h0003);
        rd(8'h28, 16'h0303);
        complete_run();
    end
endmodule : mpf_top_tb
`default_nettype wire
